/* logic/pch_pkg.sv */
// Shared constants and types of the parameter command handler.
// Assumes one 250 MHz clock and a synchronous active-high reset.
package pch_pkg;
  // ----------------------------------------
  // Frame layout and instruction codes
  // ----------------------------------------
  localparam logic [3:0] FRAME_LAST = 4'h8;
  localparam logic [7:0] INS_SET_AXIS = 8'h05;
  localparam logic [7:0] INS_GET_AXIS = 8'h06;
  localparam logic [7:0] INS_STORE_AXIS = 8'h07;
  localparam logic [7:0] INS_RESTORE_AXIS = 8'h08;
  localparam logic [7:0] INS_SET_GLOBAL = 8'h09;
  // ----------------------------------------
  // Reply status codes
  // ----------------------------------------
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_CSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  // ----------------------------------------
  // Parameter numbers and banks
  // ----------------------------------------
  localparam int AXIS_N = 64;
  localparam logic [5:0] AXIS_LAST = 6'h3f;
  localparam logic [7:0] AP_ACT_POS = 8'h01;
  localparam logic [5:0] AP_MAX_SPEED = 6'h04;
  localparam logic [7:0] MOTOR0 = 8'h00;
  localparam logic [7:0] BANK_MODULE = 8'h00;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] BANK_IRQ = 8'h03;
  localparam logic [7:0] GP_SER_ADDR = 8'h42;
  localparam logic [7:0] SER_ADDR_RST = 8'h01;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REPLY = 8'h08;
  localparam logic [7:0] REG_REPLY_VAL = 8'h0c;
  localparam logic [7:0] REG_ACCUM = 8'h10;
  localparam logic [7:0] REG_SER_ADDR = 8'h14;
  localparam int CTRL_STANDALONE = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REPLY = 1;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    PCH_OP_NONE = 3'b000,
    PCH_OP_WR = 3'b001,
    PCH_OP_RD = 3'b010,
    PCH_OP_STORE = 3'b011,
    PCH_OP_RESTORE = 3'b100
  } pch_op_t;
  typedef enum logic [1:0] {
    PCH_IDLE = 2'b00,
    PCH_READ = 2'b01
  } pch_state_t;
endpackage

/* logic/pch_ap_if.sv */
// Request and answer path between the command engine and the parameter store.
// Assumes both ends share one clock; rdata is valid the cycle after a read.
`timescale 1ns/100ps
interface pch_ap_if;
  import pch_pkg::*;
  pch_op_t op;
  logic [5:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic busy;
  logic [31:0] max_speed;
  modport host(output op, idx, wdata, input rdata, busy, max_speed);
  modport store(input op, idx, wdata, output rdata, busy, max_speed);
endinterface

/* logic/pch_frame_rx.sv */
// Assembles nine command bytes into one frame and checks its checksum.
// Assumes bytes arrive from logic on the same clock; no resync on gaps.
`timescale 1ns/100ps
module pch_frame_rx (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Byte input
  input wire logic i_take,
  input wire logic [7:0] i_data,
  // Frame output
  output logic o_vld,
  output logic o_csum_ok,
  output logic [63:0] o_frame
);
  import pch_pkg::*;

  logic [3:0] cnt_q, cnt_d;
  logic [63:0] hdr_q, hdr_d;
  logic [63:0] out_q, out_d;
  logic [7:0] sum_q, sum_d;
  logic vld_q, vld_d;
  logic ok_q, ok_d;

  always_comb begin
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    out_d = out_q;
    sum_d = sum_q;
    ok_d = ok_q;
    vld_d = 1'b0;
    if (i_take) begin
      if (cnt_q == FRAME_LAST) begin
        vld_d = 1'b1;
        ok_d = (sum_q == i_data);
        out_d = hdr_q;
        cnt_d = 4'h0;
        sum_d = 8'h00;
      end else begin
        hdr_d = {hdr_q[55:0], i_data};
        sum_d = sum_q + i_data;
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
      hdr_q <= 64'h0;
      out_q <= 64'h0;
      sum_q <= 8'h00;
      vld_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      out_q <= out_d;
      sum_q <= sum_d;
      vld_q <= vld_d;
      ok_q <= ok_d;
    end
  end

  assign o_vld = vld_q;
  assign o_csum_ok = ok_q;
  assign o_frame = out_q;
endmodule

/* logic/pch_param_store.sv */
// Axis parameter working memory with its non-volatile copy.
// Assumes the host issues no operation while busy is high.
`timescale 1ns/100ps
module pch_param_store (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Engine side
  pch_ap_if.store ap
);
  import pch_pkg::*;

  // Non-volatile copy is never reset; it models the EEPROM
  logic [31:0] work_mem [AXIS_N];
  logic [31:0] nv_mem [AXIS_N];
  logic load_q, load_d;
  logic [5:0] lidx_q, lidx_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] max_q, max_d;
  logic we, nv_we;
  logic [5:0] waddr;
  logic [31:0] wdat;

  always_comb begin
    load_d = load_q;
    lidx_d = lidx_q;
    rdata_d = rdata_q;
    max_d = max_q;
    we = 1'b0;
    nv_we = 1'b0;
    waddr = ap.idx;
    wdat = ap.wdata;
    if (load_q) begin
      we = 1'b1;
      waddr = lidx_q;
      wdat = nv_mem[lidx_q];
      lidx_d = lidx_q + 6'h01;
      load_d = (lidx_q != AXIS_LAST);
    end else begin
      case (ap.op)
        PCH_OP_WR: we = 1'b1;
        PCH_OP_RD: rdata_d = work_mem[ap.idx];
        PCH_OP_STORE: nv_we = 1'b1;
        PCH_OP_RESTORE: begin
          we = 1'b1;
          wdat = nv_mem[ap.idx];
        end
        default: we = 1'b0;
      endcase
    end
    if (we && waddr == AP_MAX_SPEED) begin
      max_d = wdat;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      load_q <= 1'b1;
      lidx_q <= 6'h00;
      rdata_q <= 32'h0;
      max_q <= 32'h0;
    end else begin
      load_q <= load_d;
      lidx_q <= lidx_d;
      rdata_q <= rdata_d;
      max_q <= max_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (we) begin
      work_mem[waddr] <= wdat;
    end
    if (nv_we) begin
      nv_mem[ap.idx] <= work_mem[ap.idx];
    end
  end

  assign ap.rdata = rdata_q;
  assign ap.busy = load_q;
  assign ap.max_speed = max_q;
endmodule

/* logic/pch_top.sv */
// Parameter command handler: decodes framed set/get/store/restore commands.
// Assumes command bytes and actual position come from logic on i_clk.
//
// Overview of operation
// - Frame is address, instruction, type, motor/bank, value MSB first, checksum.
// - Instruction 5 writes the value into the selected axis parameter, replies OK.
// - Axis parameter 4 is the maximum positioning speed.
// - Instruction 6 reads the selected axis parameter of motor 0.
// - Direct-mode read replies OK with the parameter value.
// - Standalone read also copies the value into the accumulator.
// - Direct-mode read leaves the accumulator unchanged.
// - Axis parameter 1 reads the actual motor position.
// - Instruction 7 stores the axis parameter permanently, replies OK with 0.
// - Instruction 8 reloads the axis parameter from its stored copy, replies 0.
// - After power-up every axis parameter loads from its stored copy.
// - Set values live only in volatile working memory.
// - Instruction 9 writes the value into the global parameter, replies OK.
// - Bank 0 module settings, bank 2 user variables, bank 3 interrupt setup.
// - Bank 0 writes are saved to non-volatile memory automatically; here they only raise o_gp_persist, and ser_addr resets to SER_ADDR_RST.
// - Global parameter 66 in bank 0 is the serial address.
`timescale 1ns/100ps
module pch_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Command bytes
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_rx_ready,
  // Reply
  output logic o_rep_valid,
  output logic [7:0] o_rep_ins,
  output logic [7:0] o_rep_status,
  output logic [31:0] o_rep_value,
  // Motion side
  input wire logic [31:0] i_act_pos,
  output logic [31:0] o_max_speed,
  output logic [31:0] o_accum,
  output logic [7:0] o_ser_addr,
  // Global parameter writes
  output logic o_gp_wr,
  output logic [7:0] o_gp_bank,
  output logic [7:0] o_gp_type,
  output logic [31:0] o_gp_value,
  output logic o_gp_persist
);
  import pch_pkg::*;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  pch_ap_if ap();
  logic f_vld, f_csum_ok;
  logic [63:0] f_frame;
  logic [7:0] f_addr, f_ins, f_type, f_bank;
  logic [31:0] f_value;

  pch_frame_rx u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_take(i_rx_valid && o_rx_ready),
    .i_data(i_rx_data),
    .o_vld(f_vld),
    .o_csum_ok(f_csum_ok),
    .o_frame(f_frame)
  );

  pch_param_store u_store (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .ap(ap.store)
  );

  assign f_addr = f_frame[63:56];
  assign f_ins = f_frame[55:48];
  assign f_type = f_frame[47:40];
  assign f_bank = f_frame[39:32];
  assign f_value = f_frame[31:0];

  // ----------------------------------------
  // Command check
  // ----------------------------------------
  function automatic logic [7:0] f_check(input logic [7:0] ins, input logic [7:0] typ,
                                        input logic [7:0] bank);
    logic [7:0] st;
    st = ST_OK;
    if (ins >= INS_SET_AXIS && ins <= INS_RESTORE_AXIS) begin
      if (typ >= 8'(AXIS_N)) begin
        st = ST_BAD_TYPE;
      end else if (bank != MOTOR0) begin
        st = ST_BAD_VALUE;
      end
    end else if (ins == INS_SET_GLOBAL) begin
      if (bank != BANK_MODULE && bank != BANK_USER && bank != BANK_IRQ) begin
        st = ST_BAD_VALUE;
      end
    end else begin
      st = ST_BAD_CMD;
    end
    return st;
  endfunction

  pch_state_t state_q, state_d;
  logic standalone_q, standalone_d;
  logic rep_pend_q, rep_pend_d;
  logic rep_valid_q, rep_valid_d;
  logic [7:0] rep_ins_q, rep_ins_d;
  logic [7:0] rep_status_q, rep_status_d;
  logic [31:0] rep_value_q, rep_value_d;
  logic [31:0] accum_q, accum_d;
  logic [7:0] ser_addr_q, ser_addr_d;
  logic rd_pos_q, rd_pos_d;
  logic gp_wr_q, gp_wr_d;
  logic [7:0] gp_bank_q, gp_bank_d;
  logic [7:0] gp_type_q, gp_type_d;
  logic [31:0] gp_value_q, gp_value_d;
  logic gp_persist_q, gp_persist_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic f_hit, f_go;
  logic [7:0] f_status;
  logic apb_wr;

  // Frames to another address are dropped without a reply
  assign f_hit = state_q == PCH_IDLE && f_vld && f_addr == ser_addr_q;
  assign f_status = f_csum_ok ? f_check(f_ins, f_type, f_bank) : ST_BAD_CSUM;
  assign f_go = f_hit && f_status == ST_OK;
  assign apb_wr = i_psel && i_penable && i_pwrite;

  // ----------------------------------------
  // Command engine and register file
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    standalone_d = standalone_q;
    rep_valid_d = 1'b0;
    rep_ins_d = rep_ins_q;
    rep_status_d = rep_status_q;
    rep_value_d = rep_value_q;
    accum_d = accum_q;
    ser_addr_d = ser_addr_q;
    rd_pos_d = rd_pos_q;
    gp_wr_d = 1'b0;
    gp_bank_d = gp_bank_q;
    gp_type_d = gp_type_q;
    gp_value_d = gp_value_q;
    gp_persist_d = gp_persist_q;
    ap.op = PCH_OP_NONE;
    ap.idx = f_type[5:0];
    ap.wdata = f_value;
    case (state_q)
      PCH_IDLE: begin
        if (f_hit) begin
          rep_ins_d = f_ins;
          rep_status_d = f_status;
          rep_value_d = 32'h0;
          rep_valid_d = 1'b1;
          if (f_go) begin
            case (f_ins)
              INS_SET_AXIS: ap.op = PCH_OP_WR;
              INS_GET_AXIS: begin
                ap.op = PCH_OP_RD;
                rep_valid_d = 1'b0;
                rd_pos_d = (f_type == AP_ACT_POS);
                state_d = PCH_READ;
              end
              INS_STORE_AXIS: ap.op = PCH_OP_STORE;
              INS_RESTORE_AXIS: ap.op = PCH_OP_RESTORE;
              INS_SET_GLOBAL: begin
                gp_wr_d = 1'b1;
                gp_bank_d = f_bank;
                gp_type_d = f_type;
                gp_value_d = f_value;
                gp_persist_d = (f_bank == BANK_MODULE);
                if (f_bank == BANK_MODULE && f_type == GP_SER_ADDR) begin
                  ser_addr_d = f_value[7:0];
                end
              end
              default: rep_valid_d = 1'b1;
            endcase
          end
        end
      end
      PCH_READ: begin
        rep_value_d = rd_pos_q ? i_act_pos : ap.rdata;
        rep_valid_d = 1'b1;
        if (standalone_q) begin
          accum_d = rep_value_d;
        end
        state_d = PCH_IDLE;
      end
      default: state_d = PCH_IDLE;
    endcase
    // Reply flag: a new reply wins over a clear in the same cycle
    rep_pend_d = rep_pend_q;
    if (apb_wr && i_paddr == REG_STATUS && i_pwdata[STAT_REPLY]) begin
      rep_pend_d = 1'b0;
    end
    if (rep_valid_d) begin
      rep_pend_d = 1'b1;
    end
    if (apb_wr && i_paddr == REG_CTRL) begin
      standalone_d = i_pwdata[CTRL_STANDALONE];
    end
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (i_psel && !i_penable) begin
      pslverr_d = 1'b0;
      case (i_paddr)
        REG_CTRL: prdata_d = {31'h0, standalone_q};
        REG_STATUS: prdata_d = {30'h0, rep_pend_q, ap.busy || state_q != PCH_IDLE};
        REG_REPLY: prdata_d = {16'h0, rep_ins_q, rep_status_q};
        REG_REPLY_VAL: prdata_d = rep_value_q;
        REG_ACCUM: prdata_d = accum_q;
        REG_SER_ADDR: prdata_d = {24'h0, ser_addr_q};
        default: begin
          prdata_d = 32'h0;
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= PCH_IDLE;
      standalone_q <= 1'b0;
      rep_pend_q <= 1'b0;
      rep_valid_q <= 1'b0;
      rep_ins_q <= 8'h00;
      rep_status_q <= 8'h00;
      rep_value_q <= 32'h0;
      accum_q <= 32'h0;
      ser_addr_q <= SER_ADDR_RST;
      rd_pos_q <= 1'b0;
      gp_wr_q <= 1'b0;
      gp_bank_q <= 8'h00;
      gp_type_q <= 8'h00;
      gp_value_q <= 32'h0;
      gp_persist_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      standalone_q <= standalone_d;
      rep_pend_q <= rep_pend_d;
      rep_valid_q <= rep_valid_d;
      rep_ins_q <= rep_ins_d;
      rep_status_q <= rep_status_d;
      rep_value_q <= rep_value_d;
      accum_q <= accum_d;
      ser_addr_q <= ser_addr_d;
      rd_pos_q <= rd_pos_d;
      gp_wr_q <= gp_wr_d;
      gp_bank_q <= gp_bank_d;
      gp_type_q <= gp_type_d;
      gp_value_q <= gp_value_d;
      gp_persist_q <= gp_persist_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // No bytes are taken while a read is pending or the power-up load runs
  assign o_rx_ready = state_q == PCH_IDLE && !ap.busy;
  assign o_pready = i_psel && i_penable;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_rep_valid = rep_valid_q;
  assign o_rep_ins = rep_ins_q;
  assign o_rep_status = rep_status_q;
  assign o_rep_value = rep_value_q;
  assign o_max_speed = ap.max_speed;
  assign o_accum = accum_q;
  assign o_ser_addr = ser_addr_q;
  assign o_gp_wr = gp_wr_q;
  assign o_gp_bank = gp_bank_q;
  assign o_gp_type = gp_type_q;
  assign o_gp_value = gp_value_q;
  assign o_gp_persist = gp_persist_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  property p_bad_csum;
    f_hit && !f_csum_ok |=> o_rep_valid && o_rep_status == ST_BAD_CSUM;
  endproperty
  a_bad_csum: assert property (p_bad_csum) else $error("bad checksum not reported");

  property p_set_speed;
    f_go && f_ins == INS_SET_AXIS && f_type[5:0] == AP_MAX_SPEED
      |=> o_max_speed == $past(f_value) && o_rep_status == ST_OK && o_rep_valid;
  endproperty
  a_set_speed: assert property (p_set_speed) else $error("speed write lost");

  property p_get_reply;
    f_go && f_ins == INS_GET_AXIS |=> !o_rep_valid ##1 o_rep_valid && o_rep_status == ST_OK;
  endproperty
  a_get_reply: assert property (p_get_reply) else $error("read reply timing");

  property p_get_pos;
    f_go && f_ins == INS_GET_AXIS && f_type == AP_ACT_POS |=> ##1 o_rep_value == $past(i_act_pos);
  endproperty
  a_get_pos: assert property (p_get_pos) else $error("position not returned");

  property p_accum_direct;
    !standalone_q |=> $stable(accum_q);
  endproperty
  a_accum_direct: assert property (p_accum_direct) else $error("accumulator moved");

  property p_accum_stand;
    state_q == PCH_READ && standalone_q |=> accum_q == o_rep_value && o_rep_valid;
  endproperty
  a_accum_stand: assert property (p_accum_stand) else $error("accumulator not loaded");

  property p_store_reply;
    f_go && (f_ins == INS_STORE_AXIS || f_ins == INS_RESTORE_AXIS)
      |=> o_rep_valid && o_rep_value == 32'h0 && o_rep_status == ST_OK;
  endproperty
  a_store_reply: assert property (p_store_reply) else $error("store reply wrong");

  property p_ser_addr;
    f_go && f_ins == INS_SET_GLOBAL && f_bank == BANK_MODULE && f_type == GP_SER_ADDR
      |=> o_ser_addr == $past(f_value[7:0]) && o_gp_persist;
  endproperty
  a_ser_addr: assert property (p_ser_addr) else $error("serial address not set");

  property p_persist;
    o_gp_wr |-> o_gp_persist == (o_gp_bank == BANK_MODULE);
  endproperty
  a_persist: assert property (p_persist) else $error("bank 0 persist flag wrong");

  property p_no_rx;
    state_q == PCH_READ |-> !o_rx_ready;
  endproperty
  a_no_rx: assert property (p_no_rx) else $error("bytes taken during read");

  c_set: cover property (f_go && f_ins == INS_SET_AXIS);
  c_get_stand: cover property (state_q == PCH_READ && standalone_q);
  c_bad_csum: cover property (f_hit && !f_csum_ok);
  c_global: cover property (o_gp_wr && o_gp_persist);
endmodule

/* tb/pch_host_model.sv */
// Host side of the command link: sends nine-byte frames and waits for replies.
// Assumes the handler takes a byte on a rising edge with valid and ready both high.
`timescale 1ns/100ps
module pch_host_model (
  // Clock
  input wire logic i_clk,
  // Command bytes
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  // Reply strobe
  input wire logic i_rep_valid,
  output logic o_got
);
  // ----------------------------------------
  // Frame sender
  // ----------------------------------------
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_got = 1'b0;
  end
  // Bad flips checksum bits on purpose
  task automatic send(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] typ,
                      input logic [7:0] mb, input logic [31:0] val, input logic [7:0] bad);
    logic [7:0] b [9];
    logic [7:0] sum;
    int n;
    b = '{adr, ins, typ, mb, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum = sum + b[i];
    b[8] = sum ^ bad;
    for (int i = 0; i < 9; i++) begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_data <= b[i];
      @(negedge i_clk);
      while (i_rx_ready !== 1'b1) @(negedge i_clk);
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    // Released line shows a changed value, never the stale byte
    o_rx_data <= ~b[8];
    o_got = 1'b0;
    n = 0;
    // No next frame before the reply or a short wait
    while (!o_got && n < 8) begin
      @(negedge i_clk);
      o_got = (i_rep_valid === 1'b1);
      n++;
    end
  endtask
endmodule

/* tb/pch_tb_top.sv */
// Self-checking bench of the parameter command handler.
// Assumes the host model drives command bytes and the bench drives APB.
`timescale 1ns/100ps
module pch_tb_top;
  import pch_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rx_valid, rx_ready, rep_valid, got;
  logic gp_wr, gp_persist;
  logic [7:0] paddr, rx_data, rep_ins, rep_status, ser_addr, gp_bank, gp_type, adr;
  logic [31:0] pwdata, prdata, rep_value, act_pos, max_speed, accum, gp_value, rd;
  logic err;
  int miscompares = 0;
  int checked = 0;
  pch_top i_pch_top (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_rep_valid(rep_valid),
    .o_rep_ins(rep_ins), .o_rep_status(rep_status), .o_rep_value(rep_value), .i_act_pos(act_pos),
    .o_max_speed(max_speed), .o_accum(accum), .o_ser_addr(ser_addr), .o_gp_wr(gp_wr), .o_gp_bank(gp_bank),
    .o_gp_type(gp_type), .o_gp_value(gp_value), .o_gp_persist(gp_persist));
  pch_host_model i_pch_host_model (.i_clk(clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_rx_ready(rx_ready), .i_rep_valid(rep_valid), .o_got(got));
  // ----------------------------------------
  // Clock, shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (200) begin
      @(negedge clk);
      if (rx_ready === 1'b1) break;
    end
    chk("rx_ready", {31'h0, rx_ready}, 32'h1);
  endtask
  // Sends one frame; cv selects whether the reply value is judged
  task automatic cmd(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] mb, input logic [31:0] val,
                     input logic [7:0] bad, input logic [7:0] st, input logic cv, input logic [31:0] ev);
    i_pch_host_model.send(adr, ins, typ, mb, val, bad);
    chk("got", {31'h0, got}, 32'h1);
    chk("rep_ins", {24'h0, rep_ins}, {24'h0, ins});
    chk("rep_status", {24'h0, rep_status}, {24'h0, st});
    if (cv) chk("rep_value", rep_value, ev);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_set_get();
    cmd(INS_SET_AXIS, 8'h04, MOTOR0, 32'd51200, 8'h00, ST_OK, 1'b1, 32'h0);
    chk("max_speed", max_speed, 32'd51200);
    cmd(INS_GET_AXIS, 8'h04, MOTOR0, 32'h0, 8'h00, ST_OK, 1'b1, 32'd51200);
    chk("accum_direct", accum, 32'h0);
    apb(1'b0, REG_REPLY_VAL, 32'h0);
    chk("reg_reply_val", rd, 32'd51200);
    apb(1'b0, REG_REPLY, 32'h0);
    chk("reg_reply", rd, {16'h0, INS_GET_AXIS, ST_OK});
    chk("mapped_err", {31'h0, err}, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("reply_pending", rd, 32'h1 << STAT_REPLY);
    apb(1'b1, REG_STATUS, 32'h1 << STAT_REPLY);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("reply_cleared", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
  endtask
  task automatic t_standalone();
    apb(1'b1, REG_CTRL, 32'h1);
    act_pos <= 32'h8765_4321;
    cmd(INS_GET_AXIS, AP_ACT_POS, MOTOR0, 32'h0, 8'h00, ST_OK, 1'b1, 32'h8765_4321);
    chk("accum_standalone", accum, 32'h8765_4321);
    apb(1'b0, REG_ACCUM, 32'h0);
    chk("reg_accum", rd, 32'h8765_4321);
    apb(1'b1, REG_CTRL, 32'h0);
  endtask
  task automatic t_persist();
    cmd(INS_SET_AXIS, 8'h04, MOTOR0, 32'd1000, 8'h00, ST_OK, 1'b1, 32'h0);
    cmd(INS_STORE_AXIS, 8'h04, MOTOR0, 32'hdead_beef, 8'h00, ST_OK, 1'b1, 32'h0);
    cmd(INS_SET_AXIS, 8'h04, MOTOR0, 32'd2000, 8'h00, ST_OK, 1'b1, 32'h0);
    cmd(INS_RESTORE_AXIS, 8'h04, MOTOR0, 32'h0, 8'h00, ST_OK, 1'b1, 32'h0);
    chk("restored", max_speed, 32'd1000);
    cmd(INS_SET_AXIS, 8'h04, MOTOR0, 32'd3000, 8'h00, ST_OK, 1'b1, 32'h0);
    do_reset();
    chk("reloaded", max_speed, 32'd1000);
    cmd(INS_GET_AXIS, 8'h04, MOTOR0, 32'h0, 8'h00, ST_OK, 1'b1, 32'd1000);
  endtask
  task automatic t_errors();
    cmd(INS_SET_AXIS, 8'h04, MOTOR0, 32'd7, 8'h01, ST_BAD_CSUM, 1'b0, 32'h0);
    cmd(INS_SET_AXIS, 8'h04, 8'h01, 32'd7, 8'h00, ST_BAD_VALUE, 1'b0, 32'h0);
    cmd(INS_SET_AXIS, 8'h40, MOTOR0, 32'd7, 8'h00, ST_BAD_TYPE, 1'b0, 32'h0);
    cmd(8'h02, 8'h00, MOTOR0, 32'd7, 8'h00, ST_BAD_CMD, 1'b0, 32'h0);
    chk("speed_kept", max_speed, 32'd1000);
  endtask
  task automatic t_global();
    logic [7:0] banks [3];
    banks = '{BANK_MODULE, BANK_USER, BANK_IRQ};
    foreach (banks[k]) begin
      cmd(INS_SET_GLOBAL, 8'h05, banks[k], 32'h100 + k, 8'h00, ST_OK, 1'b0, 32'h0);
      chk("gp_wr", {31'h0, gp_wr}, 32'h1);
      chk("gp_bank", {24'h0, gp_bank}, {24'h0, banks[k]});
      chk("gp_type", {24'h0, gp_type}, 32'h5);
      chk("gp_value", gp_value, 32'h100 + k);
      chk("gp_persist", {31'h0, gp_persist}, {31'h0, banks[k] == BANK_MODULE});
    end
    cmd(INS_SET_GLOBAL, 8'h05, 8'h01, 32'h1, 8'h00, ST_BAD_VALUE, 1'b0, 32'h0);
    cmd(INS_SET_GLOBAL, GP_SER_ADDR, BANK_MODULE, 32'h3, 8'h00, ST_OK, 1'b0, 32'h0);
    chk("ser_addr", {24'h0, ser_addr}, 32'h3);
    apb(1'b0, REG_SER_ADDR, 32'h0);
    chk("reg_ser_addr", rd, 32'h3);
    i_pch_host_model.send(8'h01, INS_GET_AXIS, 8'h04, MOTOR0, 32'h0, 8'h00);
    chk("old_addr_silent", {31'h0, got}, 32'h0);
    adr = 8'h03;
    cmd(INS_GET_AXIS, 8'h04, MOTOR0, 32'h0, 8'h00, ST_OK, 1'b1, 32'd1000);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    act_pos = 32'h0;
    adr = 8'h01;
    do_reset();
    chk("ser_addr_rst", {24'h0, ser_addr}, {24'h0, SER_ADDR_RST});
    t_set_get();
    t_standalone();
    t_persist();
    t_errors();
    t_global();
    report_and_stop();
  end
  // Whole run is a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule
